// >>> verilog/slc_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial-link host command port.
// Assumes inclusion by bare name from the package and design modules.
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH

// ****************************************
// Register selects (port-level, no bus)
// ****************************************
`define SLC_SEL_COMMAND       1'b0
`define SLC_SEL_DATA          1'b1

// ****************************************
// Command word fields
// ****************************************
`define SLC_CMD_W             16
`define SLC_BIT_IGNORE        31
`define SLC_BIT_WRITE         15
`define SLC_BIT_RESET         14
`define SLC_BIT_REQUEST       13
`define SLC_BIT_EXCHANGE      12
`define SLC_BIT_STARTSTOP     11
`define SLC_TYPE_HI           10
`define SLC_TYPE_LO           8
`define SLC_MASK_HI           7
`define SLC_MASK_LO           0
`define SLC_TYPE_STOP         3'h0
`define SLC_TYPE_NORMAL       3'h1
`define SLC_TYPE_SETUP        3'h7
`define SLC_STOP_ALL_CODE     16'h0800
`define SLC_CMD_IDLE          16'h0000
`define SLC_DATA_RESET        8'h00

// ****************************************
// Local parameter table
// ****************************************
`define SLC_PARAM_DEPTH       8
`define SLC_PARAM_AW          3
`define SLC_IFACE_TYPE        8'h12
`define SLC_IFACE_WIDTH       8'h08
`define SLC_MAJOR_REV         8'h01
`define SLC_MINOR_REV         8'h00
`define SLC_PROC_TYPE         8'h01
`define SLC_CHANNELS          8'h08

// ****************************************
// Timing
// ****************************************
`define SLC_CLK_NS            100
`define SLC_RESET_HOLD_NS     400
`define SLC_RESET_HOLD_CYC    ((`SLC_RESET_HOLD_NS + `SLC_CLK_NS - 1) / `SLC_CLK_NS)
`define SLC_XFER_TIMEOUT_NS   25600
`define SLC_XFER_TIMEOUT_CYC  (`SLC_XFER_TIMEOUT_NS / `SLC_CLK_NS)

`endif

// >>> verilog/slc_pkg.sv
// Types shared by the serial-link host command port modules.
// Assumes slc_cfg.svh is on the include path.
`default_nettype none
`include "slc_cfg.svh"

package slc_pkg;
    typedef logic [`SLC_CMD_W-1:0]      slc_cmd_t;
    typedef logic [7:0]                 slc_byte_t;
    typedef logic [`SLC_PARAM_AW-1:0]   slc_paddr_t;

    typedef enum logic [2:0] {
        SLC_OP_NONE,
        SLC_OP_STOP,
        SLC_OP_START,
        SLC_OP_SETUP,
        SLC_OP_EXCHANGE,
        SLC_OP_PREAD,
        SLC_OP_PWRITE
    } slc_op_t;
endpackage

`default_nettype wire

// >>> verilog/slc_param_mem.sv
// Small local parameter memory; read data come out of a register.
// Assumes a single clock and synchronous active-high reset from the parent.
`default_nettype none
`include "slc_cfg.svh"

module slc_param_mem (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               wr_en,
    input  wire slc_pkg::slc_paddr_t addr,
    input  wire slc_pkg::slc_byte_t wr_data,
    output var  slc_pkg::slc_byte_t rd_data
);
    import slc_pkg::*;

    slc_byte_t mem [`SLC_PARAM_DEPTH];

    // Reset reloads the identification bytes; writes may overwrite them until the next reset
    always_ff @(posedge clk) begin
        if (rst) begin
            mem[0] <= `SLC_IFACE_TYPE;
            mem[1] <= `SLC_IFACE_WIDTH;
            mem[2] <= `SLC_MAJOR_REV;
            mem[3] <= `SLC_MINOR_REV;
            mem[4] <= 8'h00;
            mem[5] <= 8'h00;
            mem[6] <= `SLC_PROC_TYPE;
            mem[7] <= `SLC_CHANNELS;
        end else if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[addr];
        end
    end
endmodule

`default_nettype wire

// >>> verilog/slc_decode.sv
// Combinational decode of a 16-bit command word into one operation.
// Assumes the caller has already removed ignored writes.
`default_nettype none
`include "slc_cfg.svh"

module slc_decode (
    input  wire slc_pkg::slc_cmd_t cmd,
    output var  slc_pkg::slc_op_t  op,
    output var  logic              proc_reset,
    output var  logic              stop_all
);
    import slc_pkg::*;

    wire [2:0] type_bits = cmd[`SLC_TYPE_HI:`SLC_TYPE_LO];

    always_comb begin
        op         = SLC_OP_NONE;
        proc_reset = cmd[`SLC_BIT_RESET];
        stop_all   = (cmd == `SLC_STOP_ALL_CODE);
        if (cmd[`SLC_BIT_REQUEST]) begin
            op = cmd[`SLC_BIT_WRITE] ? SLC_OP_PWRITE : SLC_OP_PREAD;
        end else if (cmd[`SLC_BIT_EXCHANGE]) begin
            op = SLC_OP_EXCHANGE;
        end else if (cmd[`SLC_BIT_STARTSTOP]) begin
            unique case (type_bits)
                `SLC_TYPE_STOP:   op = SLC_OP_STOP;
                `SLC_TYPE_NORMAL: op = SLC_OP_START;
                `SLC_TYPE_SETUP:  op = SLC_OP_SETUP;
                default:          op = SLC_OP_NONE;
            endcase
        end
    end
endmodule

`default_nettype wire

// >>> verilog/slc_command_port.sv
// Host command and data port of the serial link interface processor.
// Assumes the host uses a one-cycle strobe interface and synchronous inputs.
//
// How it works
// - Command is 16 bits, low half-word.
// - Bit 15 marks a write command.
// - Bit 14 resets processor, enables download.
// - Bit 13 marks local parameter access.
// - Bit 12 triggers process data exchange.
// - Bit 11 plus type selects stop/start/setup.
// - Bits 7..0 select channels.
// - Write starts command; zero means done.
// - Pending command reads back as written.
// - Stop-all accepted anytime, resets interface.
// - Writes with bit 31 set are dropped.
// - 8-bit data register, low byte.
// - Parameter read: request, poll, read data.
// - Parameter write: data first, then command.
// - Start leaves failed-channel mask in data.
// - Exchange leaves per-channel error mask.
// - Stop-all is 0x0800, clears channel variables.
`default_nettype none
`include "slc_cfg.svh"

module slc_command_port (
    input  wire logic               REF_CLK,
    input  wire logic               RST,
    // Register port
    input  wire logic               REG_WRITE,
    input  wire logic               REG_READ,
    input  wire logic               REG_SEL,
    input  wire logic [31:0]        REG_WDATA,
    output var  logic [31:0]        REG_RDATA,
    // Channel side
    output var  logic [7:0]         CHANNEL_ACTIVE,
    output var  logic               SETUP_MODE,
    output var  logic               PROGRAM_LOAD_ENABLE,
    output var  logic [7:0]         EXCHANGE_REQUEST,
    input  wire logic [7:0]         CHANNEL_PRESENT,
    input  wire logic [7:0]         EXCHANGE_DONE,
    input  wire logic [7:0]         EXCHANGE_ERROR,
    output var  logic               CHANNEL_VARS_CLEAR
);
    import slc_pkg::*;

    typedef enum logic [2:0] {
        SLC_IDLE,
        SLC_EXEC,
        SLC_WAIT_XFER,
        SLC_PARAM_RD,
        SLC_HOLD_RESET
    } slc_state_t;

    // ****************************************
    // Registers and state
    // ****************************************
    slc_state_t state;
    slc_cmd_t   command_word;
    slc_byte_t  parameter_byte;
    slc_byte_t  active;
    slc_byte_t  pending;
    slc_byte_t  xfer_err;
    logic [15:0] timer;
    logic       setup;
    logic       load_en;
    logic       vars_clear;

    slc_op_t    op;
    logic       proc_reset;
    logic       stop_all;
    slc_byte_t  mem_rdata;

    // ****************************************
    // Host write decode
    // ****************************************
    wire        write_ok     = REG_WRITE && !REG_WDATA[`SLC_BIT_IGNORE];
    wire        cmd_write    = write_ok && (REG_SEL == `SLC_SEL_COMMAND);
    wire        data_write   = write_ok && (REG_SEL == `SLC_SEL_DATA);
    wire        busy         = (command_word != `SLC_CMD_IDLE);
    wire        stop_all_in  = cmd_write && (REG_WDATA[15:0] == `SLC_STOP_ALL_CODE);
    // A new command is only taken when idle, stop-all is always taken
    wire        accept       = cmd_write && (!busy || stop_all_in);
    wire [7:0]  mask         = command_word[`SLC_MASK_HI:`SLC_MASK_LO];
    wire slc_paddr_t paddr   = slc_paddr_t'(command_word[`SLC_MASK_HI:`SLC_MASK_LO]);
    wire        param_wr     = (state == SLC_EXEC) && (op == SLC_OP_PWRITE);
    wire        xfer_all     = ((pending & ~EXCHANGE_DONE) == 8'h00);
    wire        timed_out    = (timer == 16'(`SLC_XFER_TIMEOUT_CYC));

    slc_decode u_decode (
        .cmd        (command_word),
        .op         (op),
        .proc_reset (proc_reset),
        .stop_all   (stop_all)
    );

    slc_param_mem u_param (
        .clk     (REF_CLK),
        .rst     (RST),
        .wr_en   (param_wr),
        .addr    (paddr),
        .wr_data (parameter_byte),
        .rd_data (mem_rdata)
    );

    // ****************************************
    // Command register
    // ****************************************
    // The command stays readable as written until the machine clears it
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            command_word <= `SLC_CMD_IDLE;
        end else if (accept) begin
            command_word <= REG_WDATA[`SLC_CMD_W-1:0];
        end else if (state != SLC_IDLE && state != SLC_EXEC && done_now()) begin
            command_word <= `SLC_CMD_IDLE;
        end
    end

    function automatic logic done_now();
        unique case (state)
            SLC_WAIT_XFER:  done_now = xfer_all || timed_out;
            SLC_PARAM_RD:   done_now = 1'b1;
            SLC_HOLD_RESET: done_now = (timer == 16'(`SLC_RESET_HOLD_CYC));
            default:        done_now = 1'b0;
        endcase
    endfunction

    // ****************************************
    // Execution state machine
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state          <= SLC_IDLE;
            active         <= 8'h00;
            setup          <= 1'b0;
            load_en        <= 1'b0;
            pending        <= 8'h00;
            xfer_err       <= 8'h00;
            timer          <= 16'h0000;
            vars_clear     <= 1'b0;
            parameter_byte <= `SLC_DATA_RESET;
        end else begin
            vars_clear <= 1'b0;
            if (accept) begin
                state <= SLC_EXEC;
                timer <= 16'h0000;
            end else begin
                unique case (state)
                    SLC_IDLE: begin
                        if (data_write) begin
                            parameter_byte <= REG_WDATA[7:0];
                        end
                    end
                    SLC_EXEC: begin
                        state <= SLC_PARAM_RD;
                        if (proc_reset) begin
                            // Hold the processor in reset briefly; channels drop with it
                            load_en <= 1'b1;
                            active  <= 8'h00;
                            pending <= 8'h00;
                            state   <= SLC_HOLD_RESET;
                        end else if (stop_all) begin
                            // An exchange cut short by the stop is dropped, or its request would hang
                            active     <= 8'h00;
                            setup      <= 1'b0;
                            pending    <= 8'h00;
                            xfer_err   <= 8'h00;
                            vars_clear <= 1'b1;
                        end else begin
                            load_en <= 1'b0;
                            unique case (op)
                                SLC_OP_STOP: active <= active & ~mask;
                                SLC_OP_START, SLC_OP_SETUP: begin
                                    active         <= active | (mask & CHANNEL_PRESENT);
                                    setup          <= (op == SLC_OP_SETUP);
                                    parameter_byte <= mask & ~CHANNEL_PRESENT;
                                end
                                SLC_OP_EXCHANGE: begin
                                    pending  <= mask;
                                    xfer_err <= 8'h00;
                                    state    <= SLC_WAIT_XFER;
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                    SLC_WAIT_XFER: begin
                        timer    <= timer + 16'h0001;
                        pending  <= pending & ~EXCHANGE_DONE;
                        xfer_err <= xfer_err | (pending & EXCHANGE_DONE & EXCHANGE_ERROR);
                        if (done_now()) begin
                            // Channels still pending at timeout count as failed
                            parameter_byte <= xfer_err | (pending & EXCHANGE_DONE & EXCHANGE_ERROR)
                                              | (timed_out ? (pending & ~EXCHANGE_DONE) : 8'h00);
                            pending        <= 8'h00;
                            state          <= SLC_IDLE;
                        end
                    end
                    SLC_PARAM_RD: begin
                        if (op == SLC_OP_PREAD) begin
                            parameter_byte <= mem_rdata;
                        end
                        state <= SLC_IDLE;
                    end
                    SLC_HOLD_RESET: begin
                        timer <= timer + 16'h0001;
                        if (done_now()) begin
                            state <= SLC_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_READ) begin
            REG_RDATA <= (REG_SEL == `SLC_SEL_COMMAND) ? {16'h0000, command_word}
                                                        : {24'h00_0000, parameter_byte};
        end
    end

    assign CHANNEL_ACTIVE      = active;
    assign SETUP_MODE          = setup;
    assign PROGRAM_LOAD_ENABLE = load_en;
    assign EXCHANGE_REQUEST    = pending;
    assign CHANNEL_VARS_CLEAR  = vars_clear;
endmodule

`default_nettype wire

// >>> verif/slc_remote_model.sv
// Behavioural model of the remote serial cards on the channel side.
// Assumes exchange requests are levels held until the port withdraws them.
`default_nettype none
module slc_remote_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] request,
    input  wire logic [7:0] respond,
    input  wire logic [7:0] fail,
    input  wire logic [7:0] delay,
    output logic      [7:0] done,
    output logic      [7:0] error
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] age;
    always_ff @(posedge clk) begin
        if (rst || request == 8'h00) age <= 8'h00;
        else if (age != 8'hff) age <= age + 8'h01;
    end
    // Cards answer after a turnaround; a silent card never answers
    assign done = (age >= delay) ? (request & respond) : 8'h00;
    // Error means nothing without done, so it toggles there
    assign error = (done & fail) | (~done & {8{age[0]}});
endmodule
`default_nettype wire

// >>> verif/slc_port_monitor.sv
// Concurrent checks on the host command port pins.
// Assumes it is bound to the port's top module; one clock domain.
`default_nettype none
module slc_port_monitor (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        REG_WRITE,
    input wire logic        REG_READ,
    input wire logic        REG_SEL,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic [7:0]  CHANNEL_ACTIVE,
    input wire logic        PROGRAM_LOAD_ENABLE,
    input wire logic [7:0]  EXCHANGE_REQUEST,
    input wire logic [7:0]  CHANNEL_PRESENT,
    input wire logic [7:0]  EXCHANGE_DONE,
    input wire logic        CHANNEL_VARS_CLEAR
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire cmd_wr = REG_WRITE && !REG_SEL && !REG_WDATA[31];
    cmd_width_a: assert property ($past(REG_READ && !REG_SEL) |-> REG_RDATA[31:16] == 16'h0000)
        else $error("command read shows upper bits");
    data_width_a: assert property ($past(REG_READ && REG_SEL) |-> REG_RDATA[31:8] == 24'h000000)
        else $error("data read shows upper bits");
    rdata_hold_a: assert property (!$past(REG_READ) |-> $stable(REG_RDATA))
        else $error("read data moved without a read");
    stop_pulse_a: assert property (cmd_wr && REG_WDATA[15:0] == 16'h0800 |-> ##[1:3] CHANNEL_VARS_CLEAR)
        else $error("stop of every channel gave no clear pulse");
    pulse_one_a: assert property (CHANNEL_VARS_CLEAR |=> !CHANNEL_VARS_CLEAR)
        else $error("clear pulse longer than one cycle");
    stop_drop_a: assert property (CHANNEL_VARS_CLEAR |-> ##[0:3] CHANNEL_ACTIVE == 8'h00 && EXCHANGE_REQUEST == 8'h00)
        else $error("channels still active after full stop");
    start_present_a: assert property ((CHANNEL_ACTIVE & ~$past(CHANNEL_ACTIVE) & ~CHANNEL_PRESENT) == 8'h00)
        else $error("absent channel became active");
    xfer_done_a: assert property (EXCHANGE_REQUEST != 8'h00 && (EXCHANGE_REQUEST & ~EXCHANGE_DONE) == 8'h00
        |-> ##[1:3] EXCHANGE_REQUEST == 8'h00)
        else $error("exchange request held after all done");
    xfer_bound_a: assert property ($rose(|EXCHANGE_REQUEST) |-> ##[1:260] EXCHANGE_REQUEST == 8'h00)
        else $error("exchange outlived its timeout");
    load_enable_a: assert property (cmd_wr && REG_WDATA[14] |-> ##[1:2] PROGRAM_LOAD_ENABLE && CHANNEL_ACTIVE == 8'h00)
        else $error("reset command did not open program load");
endmodule
bind slc_command_port slc_port_monitor u_mon (.REF_CLK(REF_CLK), .RST(RST), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CHANNEL_ACTIVE(CHANNEL_ACTIVE), .PROGRAM_LOAD_ENABLE(PROGRAM_LOAD_ENABLE), .EXCHANGE_REQUEST(EXCHANGE_REQUEST),
    .CHANNEL_PRESENT(CHANNEL_PRESENT), .EXCHANGE_DONE(EXCHANGE_DONE), .CHANNEL_VARS_CLEAR(CHANNEL_VARS_CLEAR));
`default_nettype wire

// >>> verif/slc_command_port_bench.sv
// Self-checking bench for the host command port and remote card model.
// Assumes design files, model and checker are compiled before it.
`default_nettype none
module slc_command_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        REF_CLK = 1'b0;
    logic        RST = 1'b1;
    logic        REG_WRITE = 1'b0;
    logic        REG_READ = 1'b0;
    logic        REG_SEL = 1'b0;
    logic [31:0] REG_WDATA = 32'h0;
    logic [31:0] REG_RDATA;
    logic [7:0]  CHANNEL_ACTIVE, EXCHANGE_REQUEST, EXCHANGE_DONE, EXCHANGE_ERROR;
    logic        SETUP_MODE, PROGRAM_LOAD_ENABLE, CHANNEL_VARS_CLEAR;
    logic [7:0]  CHANNEL_PRESENT = 8'h05;
    logic [7:0]  respond = 8'h05;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;
    always #50 REF_CLK = ~REF_CLK;
    slc_command_port DUT (.REF_CLK(REF_CLK), .RST(RST), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ),
        .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CHANNEL_ACTIVE(CHANNEL_ACTIVE),
        .SETUP_MODE(SETUP_MODE), .PROGRAM_LOAD_ENABLE(PROGRAM_LOAD_ENABLE), .EXCHANGE_REQUEST(EXCHANGE_REQUEST),
        .CHANNEL_PRESENT(CHANNEL_PRESENT), .EXCHANGE_DONE(EXCHANGE_DONE), .EXCHANGE_ERROR(EXCHANGE_ERROR),
        .CHANNEL_VARS_CLEAR(CHANNEL_VARS_CLEAR));
    slc_remote_model u_cards (.clk(REF_CLK), .rst(RST), .request(EXCHANGE_REQUEST), .respond(respond),
        .fail(8'h04), .delay(8'h14), .done(EXCHANGE_DONE), .error(EXCHANGE_ERROR));
    // ****************************************
    // Bus cycles and comparison
    // ****************************************
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // A hung handshake must still reach the verdict
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic sel, input logic [31:0] d);
        @(posedge REF_CLK);
        REG_WRITE <= 1'b1;
        REG_SEL <= sel;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WRITE <= 1'b0;
    endtask
    task automatic rd(input logic sel, output logic [31:0] d);
        @(posedge REF_CLK);
        REG_READ <= 1'b1;
        REG_SEL <= sel;
        @(posedge REF_CLK);
        REG_READ <= 1'b0;
        #1 d = REG_RDATA;
    endtask
    task automatic poll();
        logic [31:0] d;
        d = 32'h1;
        for (int i = 0; i < 400 && d !== 32'h0; i++) rd(1'b0, d);
        chk(d, 32'h0);
    endtask
    task automatic run(input logic [15:0] c, input logic [7:0] exp);
        logic [31:0] d;
        wr(1'b0, {16'h0, c});
        poll();
        rd(1'b1, d);
        chk(d, {24'h0, exp});
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_params();
        logic [7:0] tbl [8] = '{8'h12, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h08};
        logic [31:0] d;
        rd(1'b1, d);
        chk(d, 32'h0);
        for (int a = 0; a < 8; a++) run(16'h2000 | 16'(a), tbl[a]);
        poll();
        wr(1'b1, 32'h0000_005a);
        wr(1'b0, 32'h0000_a005);
        poll();
        // Clear the data register so the read below must come from the table
        wr(1'b1, 32'h0000_0000);
        run(16'h2005, 8'h5a);
    endtask
    task automatic t_start();
        run(16'h0903, 8'h02);
        chk({24'h0, CHANNEL_ACTIVE}, 32'h01);
        chk({31'h0, SETUP_MODE}, 32'h0);
        run(16'h0f04, 8'h00);
        chk({31'h0, SETUP_MODE}, 32'h1);
        chk({24'h0, CHANNEL_ACTIVE & 8'h04}, 32'h04);
    endtask
    task automatic t_exchange();
        logic [31:0] d;
        wr(1'b0, 32'h0000_1005);
        rd(1'b0, d);
        chk(d, 32'h0000_1005);
        wr(1'b0, 32'h8000_0000);
        wr(1'b1, 32'h0000_0077);
        rd(1'b0, d);
        chk(d, 32'h0000_1005);
        chk({24'h0, EXCHANGE_REQUEST}, 32'h05);
        poll();
        rd(1'b1, d);
        chk(d, 32'h04);
        // Channel 0 stays silent so the transfer has to time out
        respond <= 8'h00;
        run(16'h1001, 8'h01);
        respond <= 8'h05;
    endtask
    task automatic t_stops();
        logic [31:0] d;
        wr(1'b0, 32'h0000_0804);
        poll();
        chk({24'h0, CHANNEL_ACTIVE}, 32'h01);
        wr(1'b0, 32'h8000_0901);
        rd(1'b0, d);
        chk(d, 32'h0);
        wr(1'b0, 32'h0000_0a01);
        poll();
        chk({24'h0, CHANNEL_ACTIVE}, 32'h01);
        // Stop every channel while an exchange to a silent card is outstanding
        respond <= 8'h00;
        wr(1'b0, 32'h0000_1001);
        rd(1'b0, d);
        chk({24'h0, EXCHANGE_REQUEST}, 32'h01);
        wr(1'b0, 32'h0000_0800);
        poll();
        chk({24'h0, EXCHANGE_REQUEST | CHANNEL_ACTIVE}, 32'h00);
        respond <= 8'h05;
        wr(1'b0, 32'h0000_0904);
        wr(1'b0, 32'h0000_0800);
        poll();
        chk({24'h0, CHANNEL_ACTIVE}, 32'h00);
    endtask
    task automatic t_reload();
        run(16'h0901, 8'h00);
        wr(1'b0, 32'h0000_4000);
        @(posedge REF_CLK);
        #1 chk({31'h0, PROGRAM_LOAD_ENABLE}, 32'h1);
        poll();
        chk({24'h0, CHANNEL_ACTIVE}, 32'h00);
        run(16'h2000, 8'h12);
        chk({31'h0, PROGRAM_LOAD_ENABLE}, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge REF_CLK);
        RST <= 1'b0;
        t_params();
        t_start();
        t_exchange();
        t_stops();
        t_reload();
        end_of_test();
    end
endmodule
`default_nettype wire
